// >>> rtl/osd_pkg.sv
// Constants, types and helpers shared by the oscillator select block.
package osd_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [11:0] ADDR_OSC = 12'h000;
  localparam logic [11:0] ADDR_DIV = 12'h004;

  // Clock source encodings, shared by current and requested fields.
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_INTERNAL_RC = 3'h5;
  localparam logic [2:0] SRC_RSVD = 3'h6;
  localparam logic [2:0] SRC_FRC_DIV = 3'h7;

  // Primary oscillator submodes.
  localparam logic [1:0] SUB_EXT = 2'h0;
  localparam logic [1:0] SUB_XTAL = 2'h1;
  localparam logic [1:0] SUB_HS = 2'h2;

  // Switch and monitor configuration values.
  localparam logic [1:0] SWMON_BOTH_ON = 2'h0;
  localparam int SWMON_HI_BIT = 1;

  // Field positions in the oscillator control and status register.
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int SELLOCK_BIT = 7;
  localparam int PLLLOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SECEN_BIT = 1;
  localparam int INIT_BIT = 0;

  // Field positions in the clock divider register.
  localparam int ROI_BIT = 15;
  localparam int RATIO_LSB = 12;
  localparam int RATIOEN_BIT = 11;
  localparam int POST_LSB = 8;
  localparam logic [2:0] POST_RESET = 3'h3;
  localparam logic [2:0] POST_DIV256 = 3'h7;

  // Unlock keys and unlock progress values.
  localparam logic [7:0] KEY_HI_A = 8'h78;
  localparam logic [7:0] KEY_HI_B = 8'h9a;
  localparam logic [7:0] KEY_LO_A = 8'h46;
  localparam logic [7:0] KEY_LO_B = 8'h57;
  localparam logic [1:0] KEY_IDLE = 2'h0;
  localparam logic [1:0] KEY_HALF = 2'h1;
  localparam logic [1:0] KEY_ARMED = 2'h2;

  // New-clock cycles to wait before the switch takes place.
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;

  // Switch sequencer states.
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_READY = 2'b01,
    SW_PLL = 2'b10,
    SW_SETTLE = 2'b11
  } osd_sw_e;

  // Non-volatile configuration fields.
  typedef struct packed {
    logic [1:0] switchMonitor;
    logic [2:0] initialSource;
    logic [1:0] primarySubmode;
  } osd_cfg_s;

  // Complete state of the block.
  typedef struct packed {
    osd_cfg_s cfg;
    logic [2:0] curSrc;
    logic [2:0] reqSrc;
    logic [2:0] tgtSrc;
    logic selLock;
    logic pllLock;
    logic clkFail;
    logic secEn;
    logic swInit;
    logic recover_on_irq;
    logic [2:0] ratio;
    logic ratioEn;
    logic [2:0] post;
    osd_sw_e sw;
    logic [3:0] settle;
    logic [1:0] hiKey;
    logic [1:0] loKey;
    logic pllOn;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] postCnt;
    logic postTick;
    logic [6:0] dozeCnt;
    logic cpuTick;
  } osd_state_s;

  // True for sources that run through the PLL.
  function automatic logic osd_uses_pll(input logic [2:0] src);
    osd_uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
  endfunction

  // Last count of the fast RC postscaler for a code.
  function automatic logic [7:0] osd_post_last(input logic [2:0] code);
    if (code == POST_DIV256) begin
      osd_post_last = 8'hff;
    end else begin
      osd_post_last = 8'((8'h01 << code) - 8'h01);
    end
  endfunction

  // Last count of the CPU ratio divider, one less than 2 to the power of the code.
  function automatic logic [6:0] osd_doze_last(input logic [2:0] code);
    osd_doze_last = 7'((7'h01 << code) - 7'h01);
  endfunction

endpackage

// >>> rtl/osd_osc_select_divider.sv
// Oscillator selection, clock switch sequencer and clock dividers.
//
// Functional notes
// - Switching allowed only when upper config bit 0.
// - Fail-safe monitor only when both bits 0.
// - Power-on source taken from initial source field.
// - Primary modes use the primary submode field.
// - Erased configuration starts on postscaled fast RC.
// - Current source readable at bits 14 to 12.
// - Requested source writable at bits 10 to 8.
// - Requested source resets from initial source field.
// - Set-only lock refuses selection changes under monitor.
// - Monitor off: lock ignored, switching allowed when upper bit 0.
// - PLL lock bit shows PLL locked state.
// - PLL lock cleared on switch, non-PLL mode.
// - Clock fail flag set by monitor, software clears.
// - Bit 1 enables the secondary oscillator.
// - Switch bit stays set until switch completes.
// - Interrupt clears ratio enable when recover set.
// - Ratio code gives 1 to 2 power code.
// - Ratio enable off forces ratio 1 to 1.
// - Fast RC postscaler divides by code table.
// - Divider register low byte reads zero.
// - Switching off holds switch bit at zero.
// - Same source request aborts and clears switch bit.
// - Wait ten new clocks, then update current source.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module osd_osc_select_divider (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire osd_pkg::osd_cfg_s cfgWord,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oscReady,
  input wire logic pllLocked,
  input wire logic newClockTick,
  input wire logic clockFailure,
  input wire logic irqEvent,
  output logic [2:0] activeSource,
  output logic [2:0] targetSource,
  output logic [1:0] primarySubmode,
  output logic pllEnable,
  output logic secondaryOscOn,
  output logic failsafeEnable,
  output logic frcPostTick,
  output logic cpuTick
);
  import osd_pkg::*;

  osd_state_s st_reg;
  osd_state_s st_next;
  logic switchEn;
  logic fscmEn;
  logic selLocked;
  logic wrTaken;
  logic hiWr;
  logic loWr;
  logic divWr;
  logic hitOsc;
  logic hitDiv;
  logic [15:0] oscView;
  logic [15:0] divView;
  logic validStart;

  // Decoded configuration and lock conditions.
  assign switchEn = ~st_reg.cfg.switchMonitor[SWMON_HI_BIT];
  assign fscmEn = st_reg.cfg.switchMonitor == SWMON_BOTH_ON;
  assign selLocked = fscmEn & st_reg.selLock;

  // Bus decode; a write lands at the edge that sees pready high.
  assign hitOsc = paddr == ADDR_OSC;
  assign hitDiv = paddr == ADDR_DIV;
  assign wrTaken = psel & penable & st_reg.pready & pwrite;
  assign hiWr = wrTaken & hitOsc & pstrb[1];
  assign loWr = wrTaken & hitOsc & pstrb[0];
  assign divWr = wrTaken & hitDiv & pstrb[1];
  assign validStart = (st_reg.sw == SW_IDLE) & st_reg.swInit &
                      (st_reg.reqSrc != st_reg.curSrc);

  // Register read views; unimplemented bits read as zero.
  assign oscView = {1'b0, st_reg.curSrc, 1'b0, st_reg.reqSrc,
                    st_reg.selLock, 1'b0, st_reg.pllLock, 1'b0,
                    st_reg.clkFail, 1'b0, st_reg.secEn, st_reg.swInit};
  assign divView = {st_reg.recover_on_irq, st_reg.ratio, st_reg.ratioEn,
                    st_reg.post, 8'h00};

  // Next-state logic for the whole block.
  always_comb begin
    st_next = st_reg;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    // Read data is prepared in the first access cycle.
    if (psel & penable & ~st_reg.pready) begin
      st_next.pready = 1'b1;
      st_next.pslverr = ~(hitOsc | hitDiv);
      if (hitOsc) begin
        st_next.prdata = {16'h0000, oscView};
      end else if (hitDiv) begin
        st_next.prdata = {16'h0000, divView};
      end else begin
        st_next.prdata = 32'h0000_0000;
      end
    end

    // Switch sequencer.
    unique case (st_reg.sw)
      SW_IDLE: begin
        if (st_reg.swInit) begin
          if (st_reg.reqSrc == st_reg.curSrc) begin
            st_next.swInit = 1'b0;
          end else begin
            st_next.sw = SW_READY;
            st_next.tgtSrc = st_reg.reqSrc;
            st_next.clkFail = 1'b0;
          end
        end
      end
      SW_READY: begin
        if (oscReady) begin
          st_next.settle = 4'h0;
          if (osd_uses_pll(st_reg.tgtSrc)) begin
            st_next.sw = SW_PLL;
          end else begin
            st_next.sw = SW_SETTLE;
          end
        end
      end
      SW_PLL: begin
        if (pllLocked) begin
          st_next.sw = SW_SETTLE;
        end
      end
      SW_SETTLE: begin
        if (newClockTick) begin
          st_next.settle = st_reg.settle + 4'h1;
          if (st_reg.settle == SETTLE_CYCLES - 4'h1) begin
            st_next.sw = SW_IDLE;
            st_next.curSrc = st_reg.tgtSrc;
            st_next.swInit = 1'b0;
          end
        end
      end
    endcase

    // PLL lock status follows the running mode, zero while switching.
    st_next.pllLock = (st_reg.sw == SW_IDLE) & ~validStart &
                      osd_uses_pll(st_reg.curSrc) & pllLocked;
    st_next.pllOn = osd_uses_pll(st_reg.curSrc) |
                    ((st_reg.sw != SW_IDLE) & osd_uses_pll(st_reg.tgtSrc));

    // Any other write breaks an unlock sequence in progress.
    if (wrTaken & ~hiWr) begin
      st_next.hiKey = KEY_IDLE;
    end
    if (wrTaken & ~loWr) begin
      st_next.loKey = KEY_IDLE;
    end

    // High byte: two keys, then one real write of the request.
    if (hiWr) begin
      if (st_reg.hiKey == KEY_ARMED) begin
        st_next.hiKey = KEY_IDLE;
        if (~selLocked & (st_reg.sw == SW_IDLE)) begin
          st_next.reqSrc = pwdata[REQ_LSB +: 3];
        end
      end else if (pwdata[15:8] == KEY_HI_A) begin
        st_next.hiKey = KEY_HALF;
      end else if ((st_reg.hiKey == KEY_HALF) &
                   (pwdata[15:8] == KEY_HI_B)) begin
        st_next.hiKey = KEY_ARMED;
      end else begin
        st_next.hiKey = KEY_IDLE;
      end
    end

    // Low byte: two keys, then one real write of the controls.
    if (loWr) begin
      if (st_reg.loKey == KEY_ARMED) begin
        st_next.loKey = KEY_IDLE;
        st_next.selLock = st_reg.selLock | pwdata[SELLOCK_BIT];
        st_next.secEn = pwdata[SECEN_BIT];
        if (~pwdata[FAIL_BIT]) begin
          st_next.clkFail = 1'b0;
        end
        if (pwdata[INIT_BIT] & switchEn & ~selLocked &
            (st_reg.sw == SW_IDLE)) begin
          st_next.swInit = 1'b1;
        end
      end else if (pwdata[7:0] == KEY_LO_A) begin
        st_next.loKey = KEY_HALF;
      end else if ((st_reg.loKey == KEY_HALF) &
                   (pwdata[7:0] == KEY_LO_B)) begin
        st_next.loKey = KEY_ARMED;
      end else begin
        st_next.loKey = KEY_IDLE;
      end
    end

    // A failure report wins over a clear in the same cycle.
    if (fscmEn & clockFailure) begin
      st_next.clkFail = 1'b1;
    end

    // Divider register upper byte; the low byte holds nothing.
    if (divWr) begin
      st_next.recover_on_irq = pwdata[ROI_BIT];
      st_next.ratio = pwdata[RATIO_LSB +: 3];
      st_next.ratioEn = pwdata[RATIOEN_BIT];
      st_next.post = pwdata[POST_LSB +: 3];
    end
    // An interrupt overrides a write of the ratio enable.
    if (irqEvent & st_reg.recover_on_irq) begin
      st_next.ratioEn = 1'b0;
    end

    // Fast RC postscaler: one tick each divisor cycles.
    if (st_reg.postCnt >= osd_post_last(st_reg.post)) begin
      st_next.postCnt = 8'h00;
      st_next.postTick = 1'b1;
    end else begin
      st_next.postCnt = st_reg.postCnt + 8'h01;
      st_next.postTick = 1'b0;
    end

    // CPU tick: every cycle at 1:1, else every 2^code cycles.
    if (~st_reg.ratioEn |
        (st_reg.dozeCnt >= osd_doze_last(st_reg.ratio))) begin
      st_next.dozeCnt = 7'h00;
      st_next.cpuTick = 1'b1;
    end else begin
      st_next.dozeCnt = st_reg.dozeCnt + 7'h01;
      st_next.cpuTick = 1'b0;
    end

    // Synchronous reset latches the configuration fields.
    if (sys_rst) begin
      st_next = '0;
      st_next.cfg = cfgWord;
      st_next.curSrc = cfgWord.initialSource;
      st_next.reqSrc = cfgWord.initialSource;
      st_next.tgtSrc = cfgWord.initialSource;
      st_next.post = POST_RESET;
      st_next.sw = SW_IDLE;
      st_next.hiKey = KEY_IDLE;
      st_next.loKey = KEY_IDLE;
    end
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    st_reg <= st_next;
  end

  // Outputs come straight from the state register, failsafeEnable through a decode of it.
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign activeSource = st_reg.curSrc;
  assign targetSource = st_reg.tgtSrc;
  assign primarySubmode = st_reg.cfg.primarySubmode;
  assign pllEnable = st_reg.pllOn;
  assign secondaryOscOn = st_reg.secEn;
  assign failsafeEnable = fscmEn;
  assign frcPostTick = st_reg.postTick;
  assign cpuTick = st_reg.cpuTick;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // Named steps of a valid switch.
  sequence seq_valid_start;
    validStart;
  endsequence
  sequence seq_switch_open;
    (st_reg.sw == SW_READY) && !st_reg.pllLock;
  endsequence

  a_valid_start: assert property (seq_valid_start |=> seq_switch_open)
    else $error("valid switch did not start cleanly");
  a_redundant_abort: assert property (
    (st_reg.sw == SW_IDLE) && st_reg.swInit &&
    (st_reg.reqSrc == st_reg.curSrc) |=> !st_reg.swInit
  ) else $error("redundant switch not aborted");
  a_switch_off_hold: assert property (!switchEn |-> !st_reg.swInit)
    else $error("switch bit set while switching disabled");
  a_cur_update: assert property (
    $changed(st_reg.curSrc) |-> ($past(st_reg.sw) == SW_SETTLE) &&
    ($past(st_reg.settle) == SETTLE_CYCLES - 4'h1) && !st_reg.swInit
  ) else $error("current source changed outside switch end");
  a_lock_refuse: assert property (
    hiWr && selLocked |=> $stable(st_reg.reqSrc)
  ) else $error("locked request source changed");
  a_pll_clear: assert property (
    (st_reg.sw != SW_IDLE) || !osd_uses_pll(st_reg.curSrc)
    |-> !st_reg.pllLock
  ) else $error("pll lock shown during switch or non-pll mode");
  a_fail_set: assert property (fscmEn && clockFailure |=> st_reg.clkFail)
    else $error("clock failure not flagged");
  a_roi_clear: assert property (irqEvent && st_reg.recover_on_irq |=> !st_reg.ratioEn)
    else $error("interrupt did not clear ratio enable");
  a_ratio_unity: assert property (!st_reg.ratioEn |=> cpuTick)
    else $error("cpu tick missing at ratio 1 to 1");
  a_post_half: assert property (
    frcPostTick && (st_reg.post == 3'h1) && !divWr ##1 !divWr
    |-> !frcPostTick ##1 frcPostTick
  ) else $error("postscaler divide by two wrong");

  // Named steps for the sequencer end and the unlocked real writes.
  sequence seq_last_tick;
    (st_reg.sw == SW_SETTLE) && newClockTick &&
    (st_reg.settle == SETTLE_CYCLES - 4'h1);
  endsequence
  sequence seq_lo_real;
    loWr && (st_reg.loKey == KEY_ARMED);
  endsequence
  sequence seq_hi_real;
    hiWr && (st_reg.hiKey == KEY_ARMED) && !selLocked &&
    (st_reg.sw == SW_IDLE);
  endsequence

  // The switch bit stands through every step of a running switch.
  a_switch_busy: assert property (
    (st_reg.sw != SW_IDLE) |-> st_reg.swInit
  ) else $error("switch bit low while switch runs");
  a_pll_wait: assert property (
    (st_reg.sw == SW_PLL) && !pllLocked |=> (st_reg.sw == SW_PLL)
  ) else $error("switch left pll wait without lock");
  a_settle_count: assert property (
    (st_reg.sw == SW_SETTLE) && newClockTick &&
    (st_reg.settle < SETTLE_CYCLES - 4'h1) |=> (st_reg.sw == SW_SETTLE)
  ) else $error("switch ended before ten new clocks");
  a_switch_done: assert property (
    seq_last_tick |=> (st_reg.sw == SW_IDLE) && !st_reg.swInit &&
    (activeSource == $past(st_reg.tgtSrc))
  ) else $error("switch end did not update current source");

  // Status bits follow their set and clear conditions.
  a_pll_show: assert property (
    (st_reg.sw == SW_IDLE) && !validStart &&
    osd_uses_pll(st_reg.curSrc) && pllLocked |=> st_reg.pllLock
  ) else $error("pll lock bit missing while locked");
  a_fail_hold: assert property (
    st_reg.clkFail && !loWr && !validStart |=> st_reg.clkFail
  ) else $error("clock fail flag lost without a clear");
  a_lock_sticky: assert property (
    st_reg.selLock |=> st_reg.selLock
  ) else $error("selection lock cleared by software");
  a_sec_enable: assert property (
    seq_lo_real |=> (secondaryOscOn == $past(pwdata[SECEN_BIT]))
  ) else $error("secondary enable not written");
  a_req_write: assert property (
    seq_hi_real |=> (st_reg.reqSrc == $past(pwdata[REQ_LSB +: 3]))
  ) else $error("requested source not written");

  // Divider register fields and the fixed configuration.
  a_ratio_write: assert property (
    divWr |=> (st_reg.ratio == $past(pwdata[RATIO_LSB +: 3]))
  ) else $error("ratio field not written");
  a_roi_keep: assert property (
    !st_reg.recover_on_irq && !divWr |=> $stable(st_reg.ratioEn)
  ) else $error("ratio enable changed without recover bit");
  a_div_low_zero: assert property (
    pready && hitDiv |-> (prdata[7:0] == 8'h00)
  ) else $error("divider low byte not zero");
  a_cfg_const: assert property (
    $stable(st_reg.cfg)
  ) else $error("configuration changed after reset");
  a_bad_addr: assert property (
    pready && !(hitOsc || hitDiv) |-> pslverr
  ) else $error("unmapped access without error");

endmodule

// >>> bench/oscillator_select_and_divider_test.sv
// Self-checking bench for the oscillator select and divider block.
`timescale 1ns/100ps
module oscillator_select_and_divider_test;
  import osd_pkg::*;
  logic refClk, sysRst, psel, penable, pwrite;
  osd_cfg_s cfgWord;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic pready, pslverr, oscReady, pllLocked, newClockTick;
  logic clockFailure, irqEvent, pllEnable, secondaryOscOn;
  logic failsafeEnable, frcPostTick, cpuTick;
  logic [2:0] activeSource, targetSource;
  logic [1:0] primarySubmode;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int p;
  logic [31:0] q;
  logic e;

  osd_osc_select_divider osd_osc_select_divider_inst (
    .ref_clk(refClk), .sys_rst(sysRst), .cfgWord(cfgWord), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oscReady(oscReady), .pllLocked(pllLocked),
    .newClockTick(newClockTick), .clockFailure(clockFailure),
    .irqEvent(irqEvent), .activeSource(activeSource),
    .targetSource(targetSource), .primarySubmode(primarySubmode),
    .pllEnable(pllEnable), .secondaryOscOn(secondaryOscOn),
    .failsafeEnable(failsafeEnable), .frcPostTick(frcPostTick),
    .cpuTick(cpuTick)
  );

  // The clock toggles every 10 ns for a 50 MHz rate.
  initial begin
    refClk = 1'b0;
    forever #10 refClk = ~refClk;
  end

  // Prints the verdict and stops the run.
  task automatic final_report();
    if (errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cuts a hung run short after a fixed number of cycles.
  always @(posedge refClk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      final_report();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask

  // One APB transfer; data is taken at the edge that samples pready.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge refClk);
    penable <= 1'b1;
    do begin
      @(posedge refClk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge refClk);
  endtask

  // Reads a register and compares it.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string name);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(name, q, exp);
  endtask

  // Unlocks the high byte, then writes the requested source.
  task automatic setReq(input logic [2:0] src);
    apb(1'b1, 12'h000, {16'h0, KEY_HI_A, 8'h00}, 4'b0010);
    apb(1'b1, 12'h000, {16'h0, KEY_HI_B, 8'h00}, 4'b0010);
    apb(1'b1, 12'h000, {21'h0, src, 8'h00}, 4'b0010);
  endtask

  // Unlocks the low byte, then writes it.
  task automatic setLow(input logic [7:0] v);
    apb(1'b1, 12'h000, {24'h0, KEY_LO_A}, 4'b0001);
    apb(1'b1, 12'h000, {24'h0, KEY_LO_B}, 4'b0001);
    apb(1'b1, 12'h000, {24'h0, v}, 4'b0001);
  endtask

  // Sends a number of new-clock pulses.
  task automatic tick(input int n);
    @(posedge refClk);
    repeat (n) begin
      newClockTick <= 1'b1;
      @(posedge refClk);
      newClockTick <= 1'b0;
      @(posedge refClk);
    end
  endtask

  // Pulses one event input for a single cycle.
  task automatic pulse(input bit irq);
    if (irq) irqEvent <= 1'b1;
    else clockFailure <= 1'b1;
    @(posedge refClk);
    irqEvent <= 1'b0;
    clockFailure <= 1'b0;
    @(posedge refClk);
  endtask

  // Measures the spacing of pulses on one divider output.
  task automatic period(input bit cpu, output int r);
    repeat (2) begin
      r = 0;
      do begin
        @(negedge refClk);
        r++;
      end while ((cpu ? cpuTick : frcPostTick) !== 1'b1 && r < 600);
    end
    @(posedge refClk);
  endtask

  // Resets the block with a given configuration word.
  task automatic doReset(input osd_cfg_s c);
    cfgWord <= c;
    sysRst <= 1'b1;
    repeat (8) @(posedge refClk);
    sysRst <= 1'b0;
    @(posedge refClk);
  endtask

  // Main sequence of scenarios.
  initial begin
    {sysRst, psel, penable, pwrite, oscReady, pllLocked} = 6'h20;
    {newClockTick, clockFailure, irqEvent} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    cfgWord = 7'h7f;
    doReset(7'h7f);
    rd(12'h000, 32'h7700, "erased osc");
    rd(12'h004, 32'h0300, "div reset");
    chk("erased fs", failsafeEnable, 1'b0);
    setLow(8'h01);
    rd(12'h000, 32'h7700, "switch off");
    apb(1'b0, 12'h008, 32'h0, 4'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", q, 32'h0);
    doReset('{2'h0, SRC_FRC, SUB_HS});
    chk("submode", primarySubmode, SUB_HS);
    chk("fs on", failsafeEnable, 1'b1);
    apb(1'b1, 12'h000, 32'h3, 4'b0001);
    rd(12'h000, 32'h0000, "no unlock");
    oscReady <= 1'b1;
    setReq(SRC_SEC);
    setLow(8'h03);
    rd(12'h000, 32'h0403, "switching");
    chk("sec on", secondaryOscOn, 1'b1);
    chk("target", targetSource, SRC_SEC);
    tick(9);
    chk("nine ticks", activeSource, SRC_FRC);
    tick(1);
    chk("ten ticks", activeSource, SRC_SEC);
    rd(12'h000, 32'h4402, "switched");
    setLow(8'h03);
    rd(12'h000, 32'h4402, "abort");
    setReq(SRC_FRC_PLL);
    setLow(8'h03);
    tick(10);
    chk("pll wait", activeSource, SRC_SEC);
    pllLocked <= 1'b1;
    tick(10);
    chk("pll src", activeSource, SRC_FRC_PLL);
    chk("pll en", pllEnable, 1'b1);
    rd(12'h000, 32'h1122, "pll lock");
    setReq(SRC_FRC);
    setLow(8'h03);
    tick(10);
    rd(12'h000, 32'h0002, "no pll");
    pulse(1'b0);
    rd(12'h000, 32'h000a, "fail set");
    setLow(8'h02);
    rd(12'h000, 32'h0002, "fail clr");
    setLow(8'h82);
    setLow(8'h02);
    rd(12'h000, 32'h0082, "lock set");
    setReq(SRC_SEC);
    setLow(8'h83);
    tick(10);
    chk("locked src", activeSource, SRC_FRC);
    apb(1'b0, 12'h000, 32'h0, 4'h0);
    chk("locked bit0", q & 32'hf0ff, 32'h0082);
    doReset('{2'h1, SRC_LOW_POWER_INTERNAL_RC, SUB_EXT});
    rd(12'h000, 32'h5500, "sw only");
    setLow(8'h80);
    setReq(SRC_FRC_DIV);
    setLow(8'h81);
    tick(10);
    pulse(1'b0);
    rd(12'h000, 32'h7780, "lock ignored");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h004, {17'h0, 3'(c), 1'b1, 3'(c), 8'hff}, 4'hf);
      rd(12'h004, {17'h0, 3'(c), 1'b1, 3'(c), 8'h00}, "div");
      period(1'b0, p);
      chk("post", p, (c == 7) ? 256 : (1 << c));
      period(1'b1, p);
      chk("ratio", p, 1 << c);
    end
    apb(1'b1, 12'h004, 32'h3000, 4'hf);
    period(1'b1, p);
    chk("ratio off", p, 1);
    apb(1'b1, 12'h004, 32'h3800, 4'hf);
    pulse(1'b1);
    rd(12'h004, 32'h3800, "roi off");
    apb(1'b1, 12'h004, 32'hb800, 4'hf);
    pulse(1'b1);
    rd(12'h004, 32'hb000, "roi on");
    period(1'b1, p);
    chk("roi ratio", p, 1);
    final_report();
  end
endmodule
